// file: design/line_locked_dto_pll.sv
// Line-locked digital oscillator synthesizer with AHB-Lite register slave
// Function
// - The oscillator accumulates 16 times the vco reference per step and wraps by the active increment.
// - The clock output toggles so its rate is the oscillator rate divided by the divider setting rounded down to even, or by 2 for settings below 2.
// - A write of the nominal increment reloads the active increment with it.
// - Both increments are 33-bit unsigned with 6 integer and 27 fraction bits.
// - The value is the top six bits as an integer plus the low bits times two to the minus 27.
// - With the detector off the active increment is held at the nominal value.
// - The register port answers only while the oscillator is in its stable range.
// - After the port stops answering only a hardware reset recovers it.
`timescale 1ns/100ps
module line_locked_dto_pll
    import dpll_pkg::*;
#(
    parameter int unsigned sync_timeout = dpll_pkg::sync_timeout_cyc
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Video line sync pin
    input wire logic line_sync_input,
    // Synthesized clock, lock pin and interrupt
    output logic oscillator_clock_out,
    output logic lock_out,
    output logic irq
);
    import dpll_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Increment clamp helper
    function automatic logic [inc_w-1:0] clamp_inc(input logic [inc_w:0] v);
        if (v[inc_w]) begin
            clamp_inc = inc_min;
        end else if (v[inc_w-1:0] < inc_min) begin
            clamp_inc = inc_min;
        end else if (v[inc_w-1:0] > inc_max) begin
            clamp_inc = inc_max;
        end else begin
            clamp_inc = v[inc_w-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Line sync synchroniser and edge
    logic sync_m_reg, sync_s_reg, sync_d_reg;
    logic line_edge;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_m_reg <= 1'b0;
            sync_s_reg <= 1'b0;
            sync_d_reg <= 1'b0;
        end else begin
            sync_m_reg <= line_sync_input;
            sync_s_reg <= sync_m_reg;
            sync_d_reg <= sync_s_reg;
        end
    end
    assign line_edge = sync_s_reg & ~sync_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register state
    ahb_req_s req_reg, req_next;
    logic det_off_reg, det_off_next;
    logic [31:0] nom_lo_reg, nom_lo_next;
    logic [inc_w-1:0] nom_reg, nom_next;
    logic nom_load_reg, nom_load_next;
    logic [term_w-1:0] term_reg, term_next;
    logic [3:0] div_reg, div_next;
    logic [3:0] vco_reg, vco_next;
    logic [irq_w-1:0] irq_stat_reg, irq_stat_next;
    logic [irq_w-1:0] mask_reg, mask_next;
    logic [31:0] rdata_next;
    logic irq_next;
    logic [irq_w-1:0] ev;
    logic port_dead_reg, port_dead_next;
    logic [inc_w-1:0] act_reg;
    logic sync_ok_reg, locked_reg;

    always_comb begin
        req_next = req_reg;
        det_off_next = det_off_reg;
        nom_lo_next = nom_lo_reg;
        nom_next = nom_reg;
        nom_load_next = 1'b0;
        term_next = term_reg;
        div_next = div_reg;
        vco_next = vco_reg;
        mask_next = mask_reg;
        irq_stat_next = irq_stat_reg;
        rdata_next = 32'h0;
        port_dead_next = port_dead_reg;
        // Oscillator out of range latches the port dead until reset
        if (act_reg < inc_min || act_reg > inc_max) begin
            port_dead_next = 1'b1;
        end
        if (req_reg.sel && req_reg.write) begin
            unique case (req_reg.addr[7:0])
                ctrl_off: det_off_next = hwdata[ctrl_det_off_bit];
                nom_lo_off: nom_lo_next = hwdata;
                nom_hi_off: begin
                    nom_next = {hwdata[0], nom_lo_reg};
                    nom_load_next = 1'b1;
                end
                term_off: term_next = hwdata[term_w-1:0];
                div_off: div_next = hwdata[3:0];
                vco_off: vco_next = hwdata[3:0];
                irq_off: irq_stat_next = irq_stat_reg & ~hwdata[irq_w-1:0];
                mask_off: mask_next = hwdata[irq_w-1:0];
                default: ;
            endcase
        end
        // Set wins over the write-one clear
        irq_stat_next = irq_stat_next | ev;
        req_next = '{addr: haddr, write: hwrite, size: hsize,
                     sel: hsel && htrans[1] && hready && !port_dead_reg};
        if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
                ctrl_off: rdata_next[ctrl_det_off_bit] = det_off_reg;
                nom_lo_off: rdata_next = nom_reg[31:0];
                nom_hi_off: rdata_next[0] = nom_reg[32];
                term_off: rdata_next[term_w-1:0] = term_reg;
                div_off: rdata_next[3:0] = div_reg;
                vco_off: rdata_next[3:0] = vco_reg;
                stat_off: rdata_next[1:0] = {locked_reg, sync_ok_reg};
                irq_off: rdata_next[irq_w-1:0] = irq_stat_reg;
                mask_off: rdata_next[irq_w-1:0] = mask_reg;
                act_lo_off: rdata_next = act_reg[31:0];
                act_hi_off: rdata_next[0] = act_reg[32];
                default: rdata_next = 32'h0;
            endcase
        end
        irq_next = |(irq_stat_next & mask_next);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg <= '0;
            det_off_reg <= 1'b0;
            nom_lo_reg <= 32'h0;
            nom_reg <= nom_rst;
            nom_load_reg <= 1'b0;
            term_reg <= term_rst;
            div_reg <= div_rst;
            vco_reg <= vco_rst;
            irq_stat_reg <= '0;
            mask_reg <= '0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
            port_dead_reg <= 1'b0;
        end else begin
            req_reg <= req_next;
            det_off_reg <= det_off_next;
            nom_lo_reg <= nom_lo_next;
            nom_reg <= nom_next;
            nom_load_reg <= nom_load_next;
            term_reg <= term_next;
            div_reg <= div_next;
            vco_reg <= vco_next;
            irq_stat_reg <= irq_stat_next;
            mask_reg <= mask_next;
            hrdata <= rdata_next;
            hreadyout <= !port_dead_next;
            hresp <= 1'b0;
            irq <= irq_next;
            port_dead_reg <= port_dead_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital oscillator and output divider
    logic [acc_w:0] acc_reg, acc_next;
    logic [acc_w:0] wrap_lim;
    logic osc_tick;
    // Wrap point: integer and top five fraction bits of the increment, doubled
    assign wrap_lim = {22'h0, act_reg[inc_w-1:inc_frac_w-5], 1'b0};
    logic [3:0] div_cnt_reg, div_cnt_next;
    logic clk_out_next;
    always_comb begin
        // Each step adds 16 x vco multiplier; wrap at the scaled increment (64 x inc) gives f = f_vco / (4 inc)
        acc_next = acc_reg + {26'h0, vco_reg, 4'h0};
        osc_tick = 1'b0;
        if (acc_next >= wrap_lim) begin
            acc_next = acc_next - wrap_lim;
            osc_tick = 1'b1;
            // Remainder above a lowered wrap point restarts the phase
            if (acc_next >= wrap_lim) begin
                acc_next = '0;
            end
        end
        div_cnt_next = div_cnt_reg;
        clk_out_next = oscillator_clock_out;
        if (osc_tick) begin
            if (div_cnt_reg + 4'h1 >= (div_reg >> 1) || div_reg < 4'h2) begin
                div_cnt_next = 4'h0;
                clk_out_next = ~oscillator_clock_out;
            end else begin
                div_cnt_next = div_cnt_reg + 4'h1;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg <= '0;
            div_cnt_reg <= 4'h0;
            oscillator_clock_out <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            div_cnt_reg <= div_cnt_next;
            oscillator_clock_out <= clk_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase/frequency detector, lock and sync detection
    logic [term_w-1:0] line_cnt_reg, line_cnt_next;
    logic out_rise;
    logic [inc_w-1:0] act_next;
    logic [31:0] silence_reg, silence_next;
    logic sync_ok_next, locked_next;
    logic [3:0] good_reg, good_next;
    logic [inc_w:0] trial;
    logic signed [term_w+1:0] err;
    assign out_rise = clk_out_next & ~oscillator_clock_out;
    always_comb begin
        line_cnt_next = line_cnt_reg;
        act_next = act_reg;
        silence_next = silence_reg + 32'h1;
        sync_ok_next = sync_ok_reg;
        locked_next = locked_reg;
        good_next = good_reg;
        err = '0;
        trial = {1'b0, act_reg};
        ev = '0;
        if (out_rise) begin
            line_cnt_next = line_cnt_reg + 12'h1;
        end
        if (silence_reg >= sync_timeout) begin
            sync_ok_next = 1'b0;
            silence_next = silence_reg;
        end
        if (line_edge) begin
            silence_next = 32'h0;
            sync_ok_next = 1'b1;
            line_cnt_next = 12'h0;
            err = $signed({2'b00, line_cnt_reg}) - $signed({2'b00, term_reg});
            // Too many cycles per line: raise the increment to slow down
            trial = {1'b0, act_reg} + {{(inc_w-term_w-9){err[term_w+1]}}, err, 8'h0};
            if (err > $signed(lock_err_tol) || err < -$signed(lock_err_tol)) begin
                good_next = 4'h0;
                locked_next = 1'b0;
            end else if (good_reg < lock_lines) begin
                good_next = good_reg + 4'h1;
            end else begin
                locked_next = 1'b1;
            end
            if (!det_off_reg) begin
                act_next = clamp_inc(trial);
            end
        end
        if (det_off_reg || nom_load_reg) begin
            act_next = nom_reg;
        end
        if (!sync_ok_next) begin
            locked_next = 1'b0;
        end
        ev[irq_sync_lost] = sync_ok_reg & ~sync_ok_next;
        ev[irq_lock_lost] = locked_reg & ~locked_next;
        ev[irq_range] = port_dead_next & ~port_dead_reg;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_cnt_reg <= '0;
            act_reg <= nom_rst;
            silence_reg <= 32'h0;
            sync_ok_reg <= 1'b0;
            locked_reg <= 1'b0;
            good_reg <= 4'h0;
            lock_out <= 1'b0;
        end else begin
            line_cnt_reg <= line_cnt_next;
            act_reg <= act_next;
            silence_reg <= silence_next;
            sync_ok_reg <= sync_ok_next;
            locked_reg <= locked_next;
            good_reg <= good_next;
            lock_out <= locked_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_nom_reload;
        @(posedge hclk) disable iff (!hresetn) nom_load_reg |=> act_reg == $past(nom_reg);
    endproperty
    a_nom_reload: assert property (p_nom_reload) else $error("active increment not reloaded");

    property p_det_hold;
        @(posedge hclk) disable iff (!hresetn) det_off_reg ##1 det_off_reg |-> act_reg == $past(nom_reg);
    endproperty
    a_det_hold: assert property (p_det_hold) else $error("increment moved with detector off");

    property p_lo_only;
        @(posedge hclk) disable iff (!hresetn)
            req_reg.sel && req_reg.write && req_reg.addr[7:0] == nom_lo_off |=> $stable(nom_reg);
    endproperty
    a_lo_only: assert property (p_lo_only) else $error("partial increment applied");

    property p_dead_sticky;
        @(posedge hclk) disable iff (!hresetn) port_dead_reg |=> port_dead_reg && !hreadyout;
    endproperty
    a_dead_sticky: assert property (p_dead_sticky) else $error("port revived without reset");

    property p_dead_answer;
        @(posedge hclk) disable iff (!hresetn) (act_reg > inc_max) |=> !hreadyout;
    endproperty
    a_dead_answer: assert property (p_dead_answer) else $error("port answers with bad oscillator");

    property p_out_toggle;
        @(posedge hclk) disable iff (!hresetn) $changed(oscillator_clock_out) |-> $past(osc_tick);
    endproperty
    a_out_toggle: assert property (p_out_toggle) else $error("output changed without oscillator step");

    property p_inc_range;
        @(posedge hclk) disable iff (!hresetn)
            line_edge && !det_off_reg && !nom_load_reg |=> act_reg >= inc_min && act_reg <= inc_max;
    endproperty
    a_inc_range: assert property (p_inc_range) else $error("steered increment out of range");

    property p_lock_sync;
        @(posedge hclk) disable iff (!hresetn) lock_out |-> sync_ok_reg;
    endproperty
    a_lock_sync: assert property (p_lock_sync) else $error("lock without sync");

    property p_wrap;
        @(posedge hclk) disable iff (!hresetn)
            $past(wrap_lim) != '0 |-> acc_reg < $past(wrap_lim);
    endproperty
    a_wrap: assert property (p_wrap) else $error("accumulator overran");
endmodule

// file: design/dpll_pkg.sv
// Package: constants, register map and carrier types for the line-locked synthesizer
package dpll_pkg;
    localparam int unsigned inc_w = 33;
    localparam int unsigned inc_int_w = 6;
    localparam int unsigned inc_frac_w = 27;
    localparam int unsigned term_w = 12;
    localparam int unsigned acc_w = 33;
    // Register byte offsets
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] nom_lo_off = 8'h04;
    localparam logic [7:0] nom_hi_off = 8'h08;
    localparam logic [7:0] term_off = 8'h0c;
    localparam logic [7:0] div_off = 8'h10;
    localparam logic [7:0] stat_off = 8'h14;
    localparam logic [7:0] irq_off = 8'h18;
    localparam logic [7:0] mask_off = 8'h1c;
    localparam logic [7:0] act_lo_off = 8'h20;
    localparam logic [7:0] act_hi_off = 8'h24;
    localparam logic [7:0] vco_off = 8'h28;
    // Field positions
    localparam int unsigned ctrl_det_off_bit = 0;
    localparam int unsigned stat_sync_bit = 0;
    localparam int unsigned stat_lock_bit = 1;
    localparam int unsigned irq_w = 3;
    localparam int unsigned irq_sync_lost = 0;
    localparam int unsigned irq_lock_lost = 1;
    localparam int unsigned irq_range = 2;
    // Reset values and increment range limits
    localparam logic [32:0] nom_rst = 33'h0ba2e8a16;
    localparam logic [11:0] term_rst = 12'h520;
    localparam logic [3:0] div_rst = 4'h4;
    localparam logic [3:0] vco_rst = 4'h8;
    localparam logic [32:0] inc_min = 33'h080000000;
    localparam logic [32:0] inc_max = 33'h100000000;
    // Scale of one oscillator cycle: 32 in the same fixed point
    localparam logic [32:0] osc_period = 33'h100000000;
    // Timing: sync declared absent after this many clocks without a line edge
    localparam int unsigned sync_timeout_cyc = 65536;
    localparam int unsigned lock_err_tol = 2;
    localparam int unsigned lock_lines = 8;
    localparam logic [7:0] loop_gain_shift = 8'h10;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [2:0] size;
        logic sel;
    } ahb_req_s;
endpackage

// file: verification/line_sync_gen.sv
// Line sync source standing in for the incoming video timing
`timescale 1ns/100ps
module line_sync_gen (
    // Clock
    input wire logic hclk,
    // Control
    input wire logic run,
    input wire logic [15:0] period,
    // Sync pin
    output logic line_sync_input
);
    logic [15:0] cnt_reg;
    // Four-cycle pulse at each line start, low while stopped
    always @(posedge hclk) begin
        cnt_reg <= (!run || cnt_reg >= period - 16'h1) ? 16'h0 : cnt_reg + 16'h1;
        line_sync_input <= run && (cnt_reg < 16'h4);
    end
endmodule

// file: verification/tb.sv
// Self-checking testbench for the line-locked synthesizer
`timescale 1ns/100ps
module tb;
    import dpll_pkg::*;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d;} row_s;
    logic hclk, hresetn, hsel, hwrite, sync_run, line_sync, clk_out, lock_out, irq, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [15:0] period;
    int err_total, compares, n, c16, c32, c8d, c24, cl;
    row_s rows [0:21] = '{
        '{8'h0c, 1'b0, 32'h520}, '{8'h10, 1'b0, 32'h4}, '{8'h28, 1'b0, 32'h8},
        '{8'h04, 1'b0, 32'hba2e8a16}, '{8'h08, 1'b0, 32'h0}, '{8'h20, 1'b0, 32'hba2e8a16},
        '{8'h24, 1'b0, 32'h0}, '{8'h2c, 1'b1, 32'h5}, '{8'h2c, 1'b0, 32'h0},
        '{8'h00, 1'b1, 32'h1}, '{8'h00, 1'b0, 32'h1}, '{8'h04, 1'b1, 32'hc0000000},
        '{8'h20, 1'b0, 32'hba2e8a16}, '{8'h08, 1'b1, 32'h0}, '{8'h20, 1'b0, 32'hc0000000},
        '{8'h04, 1'b1, 32'h0}, '{8'h08, 1'b1, 32'h1}, '{8'h20, 1'b0, 32'h0},
        '{8'h24, 1'b0, 32'h1}, '{8'h04, 1'b1, 32'h80000000}, '{8'h08, 1'b1, 32'h0},
        '{8'h20, 1'b0, 32'h80000000}};

    line_sync_gen u_sync (.hclk(hclk), .run(sync_run), .period(period), .line_sync_input(line_sync));
    line_locked_dto_pll #(.sync_timeout(2000)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .line_sync_input(line_sync), .oscillator_clock_out(clk_out), .lock_out(lock_out), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task near(input int got, input int exp, input string m);
        compares++;
        if (got > exp + 2 || got < exp - 2) begin
            err_total++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask
    task wait_rdy;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            chk(32'h0, 32'h1, "bus hang");
            final_report();
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "resp");
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp, m);
    endtask
    task edges(input int cyc, output int c);
        logic p;
        c = 0;
        p = clk_out;
        repeat (cyc) begin
            @(posedge hclk);
            if (clk_out === 1'b1 && p !== 1'b1) c++;
            p = clk_out;
        end
    endtask
    task irq_is(input logic e, input string m);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, {31'h0, e}, m);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        {hresetn, hsel, hwrite, sync_run, htrans, haddr, hwdata} = '0;
        period = 16'd1000;
        err_total = 0;
        compares = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        chk({29'h0, hreadyout, lock_out, irq}, 32'h4, "reset outputs");
        for (int i = 0; i < 22; i++) begin
            bus(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].d, "row");
        end
        // Rate against increment and divider, detector held off
        sync_run <= 1'b1;
        edges(1000, c16);
        bus(8'h04, 1'b1, 32'h0);
        bus(8'h08, 1'b1, 32'h1);
        edges(1000, c32);
        near(c16, 2 * c32, "rate vs increment");
        bus(8'h10, 1'b1, 32'h8);
        edges(1000, c8d);
        near(c32, 2 * c8d, "rate vs divider");
        bus(8'h10, 1'b1, 32'h4);
        bus(8'h04, 1'b1, 32'hc0000000);
        bus(8'h08, 1'b1, 32'h0);
        edges(5000, c24);
        c24 = c24 / 5;
        rdc(8'h20, 32'hc0000000, "held at nominal");
        rdc(8'h14, 32'h1, "sync present");
        // Lock onto lines of 1000 clocks
        bus(8'h0c, 1'b1, c24);
        bus(8'h00, 1'b1, 32'h0);
        for (n = 0; n < 40000 && lock_out !== 1'b1; n++) @(posedge hclk);
        chk({31'h0, lock_out}, 32'h1, "lock");
        if (lock_out !== 1'b1) final_report();
        edges(1000, cl);
        near(cl, c24, "count per line");
        // Sync loss event, mask and clear
        bus(8'h18, 1'b1, 32'h7);
        bus(8'h1c, 1'b1, 32'h1);
        sync_run <= 1'b0;
        repeat (2600) @(posedge hclk);
        bus(8'h00, 1'b1, 32'h1);
        rdc(8'h14, 32'h0, "sync gone");
        bus(8'h18, 1'b0, 32'h0);
        chk(rd & 32'h1, 32'h1, "sync lost flag");
        irq_is(1'b1, "irq raised");
        bus(8'h1c, 1'b1, 32'h0);
        irq_is(1'b0, "irq masked");
        bus(8'h1c, 1'b1, 32'h1);
        irq_is(1'b1, "irq unmasked");
        bus(8'h18, 1'b1, 32'h1);
        irq_is(1'b0, "irq cleared");
        // Out-of-range increment kills the port until reset
        bus(8'h04, 1'b1, 32'h40000000);
        bus(8'h08, 1'b1, 32'h0);
        for (n = 0; n < 200 && hreadyout !== 1'b0; n++) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h0, "port dead");
        if (hreadyout !== 1'b0) final_report();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h1, "port back");
        rdc(8'h0c, 32'h520, "restart");
        final_report();
    end
endmodule
